// ===== shared/uei_pkg.sv
// Shared constants for the serial-port event and interrupt logic
// Functional notes
// - Extended enable bit 4: DMA terminal count
// - Extended enable bit 5: transmitter fully empty
// - Consumer-infrared bit 2: overrun or underrun
// - Reads return event register, writes FIFO control
// - Basic mode: four levels, none reads 0001
// - Bit 0 low while anything pending
// - Bits 2..1 give highest pending level
// - Bit 3 flags top receive time-out
// - Bits 7..6 mirror FIFO enable
// - Line error code 0110, cleared by status read
// - Receive level code 0100, level driven
// - Time-out code 1100, cleared by data read
// - Transmit code 0010, cleared by read or write
// - Modem change code 0000, cleared by read
// - Extended: one flag bit per source
// - DMA flag clears on event register read in classic DMA, else when DMA is disabled
// - Extended bit 0: receive level or time-out
// - Extended bit 1: transmit level low
// - Extended bit 2: receive error or break
// - Consumer-infrared bit 2: overrun or underrun
// - Extended bit 3: modem change unless masked
// - Extended enables bits 4 and 5
package uei_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IER  = 3'h1;
  localparam logic [2:0] ADDR_EIR  = 3'h2;
  localparam logic [2:0] ADDR_LSR  = 3'h5;
  localparam logic [2:0] ADDR_MSR  = 3'h6;

  // ----------------------------------------
  // Reset values and masks
  // ----------------------------------------
  localparam logic [7:0] IER_RESET     = 8'h00;
  localparam logic [7:0] EIR_RESET     = 8'h01;
  localparam logic [7:0] IER_EXT_MASK  = 8'h3F;
  localparam logic [7:0] IER_BASE_MASK = 8'h0F;
  localparam logic [7:0] RDATA_IDLE    = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int IE_RX     = 0;
  localparam int IE_TX     = 1;
  localparam int IE_LS     = 2;
  localparam int IE_MS     = 3;
  localparam int IE_DMA    = 4;
  localparam int IE_TXEMP  = 5;
  localparam int FCR_EN    = 0;
  localparam int EV_WIDTH  = 6;

  // ----------------------------------------
  // Basic-mode codes
  // ----------------------------------------
  localparam logic [3:0] CODE_NONE  = 4'h1;
  localparam logic [3:0] CODE_LINE  = 4'h6;
  localparam logic [3:0] CODE_RXLVL = 4'h4;
  localparam logic [3:0] CODE_RXTO  = 4'hC;
  localparam logic [3:0] CODE_TXLVL = 4'h2;
  localparam logic [3:0] CODE_MODEM = 4'h0;
  localparam logic [1:0] FIFOS_ON   = 2'h3;
  localparam logic [1:0] FIFOS_OFF  = 2'h0;
  localparam logic [1:0] RSVD_ZERO  = 2'h0;

  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_LINE,
    SRC_RXLVL,
    SRC_RXTO,
    SRC_TXLVL,
    SRC_MODEM
  } uei_src_e;

endpackage

// ===== core/uei_sync2.sv
// Two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
module uei_sync2
  import uei_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_async,
  output logic      o_sync
);

  logic meta;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      meta   <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule // uei_sync2

// ===== core/uei_event_flag.sv
// Sticky event flag where a set beats a simultaneous clear
`timescale 1ns/100ps
module uei_event_flag
  import uei_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_set,
  input  wire logic i_clear,
  output logic      o_flag
);

  logic next_flag;

  // Set wins so an event landing on the clearing read is kept
  assign next_flag = i_set | (o_flag & ~i_clear);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_flag <= 1'b0;
    end else begin
      o_flag <= next_flag;
    end
  end

endmodule // uei_event_flag

// ===== core/uei_event_irq.sv
// Interrupt enable, event identification and request logic
`timescale 1ns/100ps
module uei_event_irq
  import uei_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // Host port
  input  wire logic [2:0] i_addr,
  input  wire logic       i_rd,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  // Mode controls
  input  wire logic       i_extended_select,
  input  wire logic       i_ir_mode,
  input  wire logic       i_cir_mode,
  input  wire logic       i_ir_modem_status_select,
  input  wire logic       i_classic_dma,
  input  wire logic       i_dma_enabled,
  // Receiver, transmitter, modem and DMA sources
  input  wire logic       i_rx_level,
  input  wire logic       i_rx_timeout,
  input  wire logic       i_line_error,
  input  wire logic       i_rx_overrun,
  input  wire logic       i_tx_underrun,
  input  wire logic       i_tx_level,
  input  wire logic       i_tx_all_empty,
  input  wire logic       i_modem_change,
  input  wire logic       i_dma_tc,
  // Results
  output logic            o_irq,
  output logic            o_fifos_on
);

  // ----------------------------------------
  // Host access decode
  // ----------------------------------------
  logic       rd_eir;
  logic       rd_lsr;
  logic       rd_msr;
  logic       rd_data;
  logic       wr_ier;
  logic       wr_fcr;
  logic       wr_data;

  assign rd_eir  = i_rd & (i_addr == ADDR_EIR);
  assign wr_fcr  = i_wr & (i_addr == ADDR_EIR);
  assign rd_lsr  = i_rd & (i_addr == ADDR_LSR);
  assign rd_msr  = i_rd & (i_addr == ADDR_MSR);
  assign rd_data = i_rd & (i_addr == ADDR_DATA);
  assign wr_ier  = i_wr & (i_addr == ADDR_IER);
  assign wr_data = i_wr & (i_addr == ADDR_DATA);

  // ----------------------------------------
  // Enable register and FIFO enable
  // ----------------------------------------
  logic [7:0] interrupt_enable_ctl;
  logic [7:0] next_ier;
  logic [7:0] ier_mask;
  logic       fcr_fifo_en;
  logic       fifo_on;
  logic       ext;

  assign ext      = i_extended_select;
  // Upper enables only exist in extended modes; 7..6 stay reserved
  assign ier_mask = ext ? IER_EXT_MASK : IER_BASE_MASK;
  assign next_ier = wr_ier ? (i_wdata & ier_mask) : (interrupt_enable_ctl & ier_mask);
  // Consumer-infrared runs its FIFOs regardless of the enable bit
  assign fifo_on  = fcr_fifo_en | i_cir_mode;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      interrupt_enable_ctl         <= IER_RESET;
      fcr_fifo_en <= 1'b0;
    end else begin
      interrupt_enable_ctl <= next_ier;
      if (wr_fcr) begin
        fcr_fifo_en <= i_wdata[FCR_EN];
      end
    end
  end

  // ----------------------------------------
  // Terminal count crossing and edges
  // ----------------------------------------
  logic tc_sync;
  logic tc_q;
  logic tc_rise;
  logic tx_level_q;
  logic tx_rise;

  uei_sync2 u_tc_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_dma_tc),
    .o_sync    (tc_sync)
  );

  assign tc_rise = tc_sync & ~tc_q;
  assign tx_rise = i_tx_level & ~tx_level_q;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      tc_q       <= 1'b0;
      tx_level_q <= 1'b0;
    end else begin
      tc_q       <= tc_sync;
      tx_level_q <= i_tx_level;
    end
  end

  // ----------------------------------------
  // Sticky event flags
  // ----------------------------------------
  logic ls_set;
  logic ls_flag;
  logic to_flag;
  logic thre_flag;
  logic thre_clr;
  logic ms_flag;
  logic dma_flag;
  logic dma_clr;
  logic top_is_tx;

  // Consumer-infrared reports overrun or underrun on the same bit
  assign ls_set   = i_cir_mode ? (i_rx_overrun | i_tx_underrun)
                               : i_line_error;
  // The read acknowledges the transmit flag only in basic mode and only when it holds top priority
  assign thre_clr = wr_data | (rd_eir & top_is_tx & ~ext);
  // Non-classic DMA leaves the flag until DMA is switched off
  assign dma_clr  = i_classic_dma ? rd_eir : ~i_dma_enabled;

  uei_event_flag u_ls_flag (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_set     (ls_set),
    .i_clear   (rd_lsr),
    .o_flag    (ls_flag)
  );

  uei_event_flag u_to_flag (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_set     (i_rx_timeout),
    .i_clear   (rd_data),
    .o_flag    (to_flag)
  );

  uei_event_flag u_thre_flag (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_set     (tx_rise),
    .i_clear   (thre_clr),
    .o_flag    (thre_flag)
  );

  uei_event_flag u_ms_flag (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_set     (i_modem_change),
    .i_clear   (rd_msr),
    .o_flag    (ms_flag)
  );

  uei_event_flag u_dma_flag (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_set     (tc_rise),
    .i_clear   (dma_clr),
    .o_flag    (dma_flag)
  );

  // ----------------------------------------
  // Basic-mode prioritised code
  // ----------------------------------------
  logic     line_pend;
  logic     rxl_pend;
  logic     rxto_pend;
  logic     tx_pend;
  logic     ms_pend;
  uei_src_e top_src;
  logic [3:0] base_code;
  logic [7:0] eir_base;

  assign line_pend = ls_flag & interrupt_enable_ctl[IE_LS];
  assign rxl_pend  = i_rx_level & interrupt_enable_ctl[IE_RX];
  assign rxto_pend = to_flag & fifo_on & interrupt_enable_ctl[IE_RX];
  assign tx_pend   = thre_flag & interrupt_enable_ctl[IE_TX];
  assign ms_pend   = ms_flag & interrupt_enable_ctl[IE_MS];

  // Four levels, line status first and modem change last
  assign top_src = line_pend ? SRC_LINE  :
                   rxl_pend  ? SRC_RXLVL :
                   rxto_pend ? SRC_RXTO  :
                   tx_pend   ? SRC_TXLVL :
                   ms_pend   ? SRC_MODEM : SRC_NONE;
  assign top_is_tx = (top_src == SRC_TXLVL);

  always_comb begin
    unique case (top_src)
      SRC_LINE:  base_code = CODE_LINE;
      SRC_RXLVL: base_code = CODE_RXLVL;
      SRC_RXTO:  base_code = CODE_RXTO;
      SRC_TXLVL: base_code = CODE_TXLVL;
      SRC_MODEM: base_code = CODE_MODEM;
      SRC_NONE:  base_code = CODE_NONE;
      default:   base_code = CODE_NONE;
    endcase
  end

  // Bit 0 is the inverted pending flag, 2..1 the level, 3 time-out
  assign eir_base = {(fifo_on ? FIFOS_ON : FIFOS_OFF),
                     RSVD_ZERO, base_code};

  // ----------------------------------------
  // Extended-mode per-source flags
  // ----------------------------------------
  logic [EV_WIDTH-1:0] ev;
  logic [7:0]          eir_ext;
  logic                ms_visible;
  logic                rx_bit;
  logic                tx_bit;

  // Flags ignore the enable bits; only the request is gated
  assign rx_bit     = fifo_on ? (i_rx_level | to_flag)
                              : i_rx_level;
  assign tx_bit     = i_tx_level;
  assign ms_visible = ms_flag & ~(i_ir_mode & i_ir_modem_status_select);
  assign ev         = {i_tx_all_empty, dma_flag, ms_visible,
                       ls_flag, tx_bit, rx_bit};
  assign eir_ext    = {RSVD_ZERO, ev};

  // ----------------------------------------
  // Interrupt request
  // ----------------------------------------
  logic [EV_WIDTH-1:0] ev_gate;
  logic                ext_irq;
  logic                base_irq;
  logic                next_irq;

  assign ev_gate[IE_RX]    = interrupt_enable_ctl[IE_RX];
  assign ev_gate[IE_TX]    = interrupt_enable_ctl[IE_TX];
  // In consumer-infrared this enable covers overrun and underrun
  assign ev_gate[IE_LS]    = interrupt_enable_ctl[IE_LS];
  assign ev_gate[IE_MS]    = interrupt_enable_ctl[IE_MS];
  assign ev_gate[IE_DMA]   = interrupt_enable_ctl[IE_DMA] & i_dma_enabled;
  assign ev_gate[IE_TXEMP] = interrupt_enable_ctl[IE_TXEMP];

  assign ext_irq  = |(ev & ev_gate);
  assign base_irq = (top_src != SRC_NONE);
  assign next_irq = ext ? ext_irq : base_irq;

  // ----------------------------------------
  // Read data and output flops
  // ----------------------------------------
  logic [7:0] eir_val;
  logic [7:0] next_rdata;

  assign eir_val    = ext ? eir_ext : eir_base;
  assign next_rdata = rd_eir                            ? eir_val :
                      (i_rd & (i_addr == ADDR_IER))     ? interrupt_enable_ctl :
                                                          RDATA_IDLE;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rdata    <= RDATA_IDLE;
      o_irq      <= 1'b0;
      o_fifos_on <= 1'b0;
    end else begin
      o_rdata    <= next_rdata;
      o_irq      <= next_irq;
      o_fifos_on <= fifo_on;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  upper_enable_clear_a : assert property (
    (!ext ##1 !ext) |-> (interrupt_enable_ctl[7:4] == 4'h0)
  ) else $error("upper enable bits held in basic mode");

  reserved_enable_a : assert property (
    (interrupt_enable_ctl[7:6] == 2'h0)
  ) else $error("reserved enable bits set");

  eir_readback_a : assert property (
    rd_eir |=> (o_rdata == $past(eir_val))
  ) else $error("event register read data wrong");

  no_pending_code_a : assert property (
    (!ext && !line_pend && !rxl_pend && !rxto_pend && !tx_pend && !ms_pend)
      |-> (eir_val[3:0] == CODE_NONE)
  ) else $error("idle code not reported");

  fifo_bits_a : assert property (
    !ext |-> (eir_val[7:4] == ((fcr_fifo_en || i_cir_mode) ? {FIFOS_ON, RSVD_ZERO}
                                                            : {FIFOS_OFF, RSVD_ZERO}))
  ) else $error("FIFO indicator bits wrong");

  line_clear_a : assert property (
    (rd_lsr && !ls_set) |=> !ls_flag
  ) else $error("line flag survived status read");

  line_set_a : assert property (
    ls_set |=> ls_flag
  ) else $error("line event lost");

  tx_clear_a : assert property (
    (wr_data && !tx_rise) |=> !thre_flag
  ) else $error("transmit flag survived data write");

  dma_clear_a : assert property (
    (rd_eir && i_classic_dma && !tc_rise) |=> !dma_flag
  ) else $error("DMA flag survived event read");

  modem_mask_a : assert property (
    (ext && i_ir_mode && i_ir_modem_status_select) |-> !eir_val[3]
  ) else $error("masked modem flag visible");

  irq_follow_a : assert property (
    (ext && |(ev & ev_gate)) |=> o_irq
  ) else $error("request not raised");

endmodule // uei_event_irq

// ===== dv/uei_dma_model.sv
// Behavioural DMA controller that signals terminal count
`timescale 1ns/100ps
module uei_dma_model (
  input  wire logic i_clk,
  input  wire logic i_fire,
  output logic      o_tc
);
  // ------------------------------------
  // Terminal count
  // ------------------------------------
  // Offset from the core clock edges, so both edges land mid-cycle
  initial o_tc = 1'b0;
  always @(posedge i_fire) begin
    #1.3;
    o_tc = 1'b1;
    repeat (3) @(posedge i_clk);
    #2.1;
    o_tc = 1'b0;
  end
endmodule // uei_dma_model

// ===== dv/tb_top.sv
// Self-checking bench for the event and interrupt logic
`timescale 1ns/100ps
module tb_top;
  import uei_pkg::*;
  // ------------------------------------
  // Stimulus and results
  // ------------------------------------
  logic       i_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [2:0] addr  = 3'h0;
  logic       rd_s  = 1'b0;
  logic       wr_s  = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic       ext   = 1'b0;
  logic       irm   = 1'b0;
  logic       cir   = 1'b0;
  logic       irms  = 1'b0;
  logic       cdma  = 1'b0;
  logic       dmae  = 1'b0;
  logic       rxl   = 1'b0;
  logic       txl   = 1'b0;
  logic       txe   = 1'b0;
  logic [4:0] pls   = 5'h00;
  logic       fire  = 1'b0;
  logic       tc;
  logic       irq;
  logic       fon;
  int         errors   = 0;
  int         n_checks = 0;

  always #2.5 i_clk = ~i_clk;

  uei_dma_model dma_u (.i_clk(i_clk), .i_fire(fire), .o_tc(tc));

  uei_event_irq dut_u (
    .i_clk(i_clk), .i_reset_n(rst_n), .i_addr(addr), .i_rd(rd_s),
    .i_wr(wr_s), .i_wdata(wdata), .o_rdata(rdata),
    .i_extended_select(ext), .i_ir_mode(irm), .i_cir_mode(cir),
    .i_ir_modem_status_select(irms), .i_classic_dma(cdma),
    .i_dma_enabled(dmae), .i_rx_level(rxl), .i_rx_timeout(pls[0]),
    .i_line_error(pls[1]), .i_rx_overrun(pls[2]), .i_tx_underrun(pls[3]),
    .i_tx_level(txl), .i_tx_all_empty(txe), .i_modem_change(pls[4]),
    .i_dma_tc(tc), .o_irq(irq), .o_fifos_on(fon)
  );

  // ------------------------------------
  // Shared tasks
  // ------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Every read is checked, so clearing reads double as checks
  task automatic rdc(input string what, input logic [2:0] a, input logic [7:0] exp);
    @(negedge i_clk);
    addr = a;
    rd_s = 1'b1;
    @(negedge i_clk);
    rd_s = 1'b0;
    chk(what, exp, rdata);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge i_clk);
    addr  = a;
    wdata = d;
    wr_s  = 1'b1;
    @(negedge i_clk);
    wr_s = 1'b0;
  endtask

  // Pulse sources: 0 timeout, 1 line, 2 overrun, 3 underrun, 4 modem
  task automatic pulse(input int k);
    @(negedge i_clk);
    pls[k] = 1'b1;
    @(negedge i_clk);
    pls[k] = 1'b0;
    repeat (2) @(negedge i_clk);
  endtask

  task automatic chk_irq(input logic exp);
    @(negedge i_clk);
    chk("irq", {7'h00, exp}, {7'h00, irq});
  endtask

  // ------------------------------------
  // Scenarios
  // ------------------------------------
  task automatic t_reset;
    rdc("eir reset", ADDR_EIR, EIR_RESET);
    rdc("ier reset", ADDR_IER, IER_RESET);
    chk("fifos reset", 8'h00, {7'h00, fon});
  endtask

  task automatic t_basic;
    wr(ADDR_IER, 8'hFF);
    rdc("ier basic", ADDR_IER, 8'h0F);
    pulse(4);
    pulse(1);
    rdc("eir line top", ADDR_EIR, 8'h06);
    chk_irq(1'b1);
    rdc("lsr", ADDR_LSR, 8'h00);
    rdc("eir modem", ADDR_EIR, 8'h00);
    rdc("msr", ADDR_MSR, 8'h00);
    rdc("eir none", ADDR_EIR, 8'h01);
    chk_irq(1'b0);
  endtask

  task automatic t_tx;
    txl = 1'b1;
    repeat (3) @(negedge i_clk);
    rdc("eir tx", ADDR_EIR, 8'h02);
    rdc("eir tx read clr", ADDR_EIR, 8'h01);
    txl = 1'b0;
    repeat (2) @(negedge i_clk);
    txl = 1'b1;
    repeat (3) @(negedge i_clk);
    wr(ADDR_DATA, 8'h5A);
    rdc("eir tx write clr", ADDR_EIR, 8'h01);
    txl = 1'b0;
  endtask

  task automatic t_fifo;
    rxl = 1'b1;
    repeat (2) @(negedge i_clk);
    rdc("eir rx level", ADDR_EIR, 8'h04);
    rxl = 1'b0;
    repeat (2) @(negedge i_clk);
    rdc("eir rx fell", ADDR_EIR, 8'h01);
    pulse(0);
    rdc("eir to fifos off", ADDR_EIR, 8'h01);
    rdc("rxd off", ADDR_DATA, 8'h00);
    wr(ADDR_EIR, 8'h01);
    rdc("eir fifos on", ADDR_EIR, 8'hC1);
    pulse(0);
    rdc("eir timeout", ADDR_EIR, 8'hCC);
    rdc("rxd", ADDR_DATA, 8'h00);
    rdc("eir to clr", ADDR_EIR, 8'hC1);
    wr(ADDR_EIR, 8'h00);
    rdc("eir fifos off", ADDR_EIR, 8'h01);
  endtask

  task automatic t_ext;
    ext = 1'b1;
    wr(ADDR_IER, 8'hFF);
    rdc("ier ext", ADDR_IER, 8'h3F);
    txe = 1'b1;
    rxl = 1'b1;
    repeat (2) @(negedge i_clk);
    rdc("eir ext lv", ADDR_EIR, 8'h21);
    wr(ADDR_IER, 8'h00);
    rdc("eir no en", ADDR_EIR, 8'h21);
    chk_irq(1'b0);
    wr(ADDR_IER, 8'h3F);
    pulse(1);
    rdc("eir ext line", ADDR_EIR, 8'h25);
    rdc("lsr ext", ADDR_LSR, 8'h00);
    irm  = 1'b1;
    irms = 1'b1;
    pulse(4);
    rdc("eir ms masked", ADDR_EIR, 8'h21);
    irms = 1'b0;
    pulse(4);
    rdc("eir ms", ADDR_EIR, 8'h29);
    rdc("msr ext", ADDR_MSR, 8'h00);
    rdc("eir ms clr", ADDR_EIR, 8'h21);
  endtask

  task automatic t_dma;
    rxl  = 1'b0;
    txe  = 1'b0;
    irm  = 1'b0;
    cdma = 1'b1;
    dmae = 1'b1;
    @(negedge i_clk);
    fire = 1'b1;
    @(negedge i_clk);
    fire = 1'b0;
    repeat (10) @(negedge i_clk);
    chk("irq dma", 8'h01, {7'h00, irq});
    rdc("eir dma", ADDR_EIR, 8'h10);
    rdc("eir dma clr", ADDR_EIR, 8'h00);
  endtask

  task automatic t_ext_lv;
    txl = 1'b1;
    repeat (2) @(negedge i_clk);
    rdc("eir ext tx", ADDR_EIR, 8'h02);
    chk_irq(1'b1);
    txl = 1'b0;
    wr(ADDR_EIR, 8'h01);
    pulse(0);
    rdc("eir ext to", ADDR_EIR, 8'h01);
    rdc("rxd ext", ADDR_DATA, 8'h00);
    rdc("eir ext to clr", ADDR_EIR, 8'h00);
    wr(ADDR_EIR, 8'h00);
    cdma = 1'b0;
    @(negedge i_clk);
    fire = 1'b1;
    @(negedge i_clk);
    fire = 1'b0;
    repeat (10) @(negedge i_clk);
    rdc("eir dma held", ADDR_EIR, 8'h10);
    rdc("eir dma kept", ADDR_EIR, 8'h10);
    chk_irq(1'b1);
    dmae = 1'b0;
    repeat (2) @(negedge i_clk);
    rdc("eir dma off", ADDR_EIR, 8'h00);
    chk_irq(1'b0);
  endtask

  task automatic t_cir;
    cir = 1'b1;
    pulse(3);
    rdc("eir underrun", ADDR_EIR, 8'h04);
    chk("fifos cir", 8'h01, {7'h00, fon});
    rdc("lsr cir", ADDR_LSR, 8'h00);
    rdc("eir cir clr", ADDR_EIR, 8'h00);
    pulse(2);
    rdc("eir overrun", ADDR_EIR, 8'h04);
    chk_irq(1'b1);
    wr(ADDR_IER, 8'h3B);
    chk_irq(1'b0);
    wr(ADDR_IER, 8'h3F);
    ext = 1'b0;
    cir = 1'b0;
    repeat (2) @(negedge i_clk);
    rdc("ier leave ext", ADDR_IER, 8'h0F);
  endtask

  // Mid-run reset must drop flags, enables and the FIFO indicator
  task automatic t_rerst;
    wr(ADDR_EIR, 8'h01);
    @(negedge i_clk);
    chk("fifos set", 8'h01, {7'h00, fon});
    rst_n = 1'b0;
    repeat (2) @(negedge i_clk);
    rst_n = 1'b1;
    rdc("eir rerst", ADDR_EIR, EIR_RESET);
    rdc("ier rerst", ADDR_IER, IER_RESET);
    chk("fifos rerst", 8'h00, {7'h00, fon});
  endtask

  // ------------------------------------
  // Run control
  // ------------------------------------
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Whole run is well under 1000 cycles
  initial begin
    #50000;
    errors++;
    give_verdict();
  end

  initial begin
    repeat (20) @(negedge i_clk);
    rst_n = 1'b1;
    t_reset();
    t_basic();
    t_tx();
    t_fifo();
    t_ext();
    t_dma();
    t_ext_lv();
    t_cir();
    t_rerst();
    give_verdict();
  end
endmodule // tb_top
